// >>> include/fpad_pkg.sv
/*
 * package for the coprocessor add / abs-of-sum / diff-of-magnitudes decode block.
 * assumes one clock and one asynchronous active-low reset shared by both ends.
 */
// Function
// - word fields: unit, sources, destination, opcode
// - memory add opcode 1000 000t s000 0000
// - memory abs-of-sum opcode 1000 1001 s000
// - reg diff-of-magnitudes opcode 0001 0111 s000
// - host-reg diff-of-magnitudes opcode 0101 0111 0000
// - postincrement: fetch then pointer plus 32
// - predecrement: pointer minus 32 then fetch
// - load sources in order, sum, store
// - add sources in opposite register files
// - diff: first from A, second from B
// - diff result is |first| minus |second|
// - abs forms exist in floating point only
// - host-reg abs forms single precision only
// - host-reg load passes first then second word
// - reg add opcode 0000 000t s000 0000
package fpad_pkg;
	// ==========================================================
	// instruction word fields
	localparam int UNIT_MSB   = 31;
	localparam int UNIT_LSB   = 29;
	localparam int SRC1_MSB   = 28;
	localparam int SRC1_LSB   = 25;
	localparam int SRC2_MSB   = 24;
	localparam int SRC2_LSB   = 21;
	localparam int DEST_MSB   = 20;
	localparam int DEST_LSB   = 16;
	localparam int OPC_MSB    = 15;
	localparam int TYPE_BIT   = 8;
	localparam int SIZE_BIT   = 7;
	// ==========================================================
	// opcode patterns with t and s cleared, and their care masks
	localparam logic [15:0] OPC_REG_ADD   = 16'h0000;
	localparam logic [15:0] OPC_MEM_ADD   = 16'h8000;
	localparam logic [15:0] OPC_MEM_ABS   = 16'h8900;
	localparam logic [15:0] OPC_REG_DIFF  = 16'h1700;
	localparam logic [15:0] OPC_HOST_DIFF = 16'h5700;
	localparam logic [15:0] MASK_TS       = 16'hfe7f;
	localparam logic [15:0] MASK_S        = 16'hff7f;
	localparam logic [15:0] MASK_ALL      = 16'hffff;
	// ==========================================================
	// host pointer step (bits) and word counts
	localparam logic [31:0] PTR_STEP      = 32'h0000_0020;
	localparam logic [2:0]  WORDS_SINGLE  = 3'h2;
	localparam logic [2:0]  WORDS_DOUBLE  = 3'h4;
	localparam logic [2:0]  UNIT_ID_RESET = 3'h0; // arbitrary default unit number
	// ==========================================================
	typedef enum logic [2:0] {
		FPAD_NONE, FPAD_SUM, FPAD_ABS_SUM, FPAD_DIFF_MAG
	} fpad_op_t;
endpackage : fpad_pkg

// >>> include/fpad_if.sv
/*
 * link between host and coprocessor end: instruction strobe, operand word strobe.
 * assumes both ends run on the same clk and rst_n.
 */
`timescale 1ns/100ps
`default_nettype none
interface fpad_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic        instr_valid; // one-cycle pulse with instr
	logic [31:0] instr;
	logic        word_valid;  // high one cycle per word, back to back across a load
	logic [31:0] word;
	logic        busy;        // coprocessor still working
	modport host (output instr_valid, output instr, output word_valid, output word,
		input busy);
	modport unit (input instr_valid, input instr, input word_valid, input word,
		output busy);
endinterface : fpad_if
`default_nettype wire

// >>> src/fpad_unit.sv
/*
 * coprocessor end: decodes add, abs-of-sum and diff-of-magnitudes words,
 * collects operand words into the source registers, then computes the result.
 * assumes the host keeps word order and addresses; arithmetic is integer-only
 * stand-in (two's complement) for the real floating-point core.
 * limits: no register file is kept; register forms work on the sources of
 * the last load, and only the destination number goes out with the answer.
 * a word for another unit number is ignored and leaves no trace.
 */
`timescale 1ns/100ps
`default_nettype none
module fpad_unit (
	input  wire logic   clk,
	input  wire logic   rst_n,
	fpad_if.unit        link,
	input  wire logic [2:0]  unit_id,
	output logic        result_valid,
	output logic [4:0]  result_reg,
	output logic [63:0] result,
	output logic        illegal
);
	typedef enum logic [1:0] {FPAD_IDLE, FPAD_LOAD, FPAD_EXEC} fpad_st_t;

	fpad_st_t           st, next_st;
	fpad_pkg::fpad_op_t op, next_op;
	// decoded class of the word on the link
	fpad_pkg::fpad_op_t dec_op;
	logic               for_us, dec_load, dec_host, dec_legal;
	logic [63:0]        src1, src2, next_src1, next_src2;
	logic [4:0]         dst, next_dst, next_result_reg;
	logic [2:0]         cnt, next_cnt, total, next_total;
	logic               dbl, next_dbl, next_busy;
	logic               next_result_valid, next_illegal;
	logic [63:0]        next_result;
	logic [15:0]        opc;
	// arithmetic taps
	logic [63:0]        m1, m2, sum, abs_sum, diff;

	// ==========================================================
	// instruction word fields
	assign opc    = link.instr[fpad_pkg::OPC_MSB:0];
	assign for_us = link.instr[fpad_pkg::UNIT_MSB:fpad_pkg::UNIT_LSB] == unit_id;

	// ==========================================================
	// arithmetic stand-in: two's complement in place of the float core,
	// so the order of the steps is real, the number format is not
	always_comb begin
		m1      = src1[63] ? -src1 : src1;
		m2      = src2[63] ? -src2 : src2;
		sum     = src1 + src2;
		abs_sum = sum[63] ? -sum : sum;
		diff    = m1 - m2;
	end

	// ==========================================================
	// opcode classes; care masks drop t and s only where a form has them,
	// so a wrong precision bit falls through to the refusal branch
	always_comb begin
		dec_op    = fpad_pkg::FPAD_NONE;
		dec_load  = 1'b0;
		dec_host  = 1'b0;
		dec_legal = 1'b1;
		if ((opc & fpad_pkg::MASK_TS) == fpad_pkg::OPC_REG_ADD) begin
			// register add: sources already loaded
			dec_op = fpad_pkg::FPAD_SUM;
		end else if ((opc & fpad_pkg::MASK_S) == fpad_pkg::OPC_REG_DIFF) begin
			// register diff: sources already loaded
			dec_op = fpad_pkg::FPAD_DIFF_MAG;
		end else if ((opc & fpad_pkg::MASK_TS) == fpad_pkg::OPC_MEM_ADD) begin
			// memory forms: words follow from the host pointer walk
			dec_op   = fpad_pkg::FPAD_SUM;
			dec_load = 1'b1;
		end else if ((opc & fpad_pkg::MASK_S) == fpad_pkg::OPC_MEM_ABS) begin
			// same move, magnitude taken at the end
			dec_op   = fpad_pkg::FPAD_ABS_SUM;
			dec_load = 1'b1;
		end else if ((opc & fpad_pkg::MASK_ALL) == fpad_pkg::OPC_HOST_DIFF) begin
			// size bit kept in the care mask: a double request is refused
			dec_op   = fpad_pkg::FPAD_DIFF_MAG;
			dec_load = 1'b1;
			dec_host = 1'b1;
		end else begin
			// other families (host-register add included) are not ours
			dec_legal = 1'b0;
		end
	end

	// ==========================================================
	// sequencing: take the word, collect operands, then execute
	always_comb begin
		// hold everything but result_valid and illegal, which drop, unless a branch below moves it
		next_st           = st;
		next_op           = op;
		next_src1         = src1;
		next_src2         = src2;
		next_dst          = dst;
		next_cnt          = cnt;
		next_total        = total;
		next_dbl          = dbl;
		next_result_valid = 1'b0;
		next_result       = result;
		next_result_reg   = result_reg;
		next_illegal      = 1'b0;
		case (st)
			FPAD_IDLE: begin
				// words are only taken here, so a new one cannot overwrite
				// the operands of one still in flight
				if (link.instr_valid && for_us) begin
					next_dst = link.instr[fpad_pkg::DEST_MSB:fpad_pkg::DEST_LSB];
					next_op  = dec_op;
					next_cnt = 3'h0;
					// host-register forms are single only
					next_dbl = opc[fpad_pkg::SIZE_BIT] && !dec_host;
					if (dec_host) begin
						next_total = fpad_pkg::WORDS_SINGLE;
					end else if (opc[fpad_pkg::SIZE_BIT]) begin
						next_total = fpad_pkg::WORDS_DOUBLE;
					end else begin
						next_total = fpad_pkg::WORDS_SINGLE;
					end
					// where the word goes next
					if (!dec_legal) begin
						// refuse: flag it once and stay idle
						next_illegal = 1'b1;
					end else if (dec_load) begin
						next_st = FPAD_LOAD;
					end else begin
						next_st = FPAD_EXEC;
					end
				end
			end
			FPAD_LOAD: begin
				if (link.word_valid) begin
					// first half of the words feed source one, rest source two
					if (cnt < (total >> 1)) begin
						next_src1 = dbl ? {src1[31:0], link.word} : {32'h0, link.word};
					end else begin
						next_src2 = dbl ? {src2[31:0], link.word} : {32'h0, link.word};
					end
					next_cnt = cnt + 3'h1;
					if (cnt + 3'h1 == total) begin
						next_st = FPAD_EXEC;
					end
				end
			end
			FPAD_EXEC: begin
				// one-cycle answer; value and register number hold until the next
				case (op)
					fpad_pkg::FPAD_ABS_SUM:  next_result = abs_sum;
					fpad_pkg::FPAD_DIFF_MAG: next_result = diff;
					default:                 next_result = sum;
				endcase
				next_result_reg   = dst;
				next_result_valid = 1'b1;
				next_st           = FPAD_IDLE;
			end
			default: begin
				// unused state code: back to idle
				next_st = FPAD_IDLE;
			end
		endcase
	end

	// ==========================================================
	// busy covers every cycle after the word is taken, so the host
	// holds its next word until the answer is out
	assign next_busy = (next_st != FPAD_IDLE);

	// ==========================================================
	// registers only; every output comes straight from here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// control state
			st           <= FPAD_IDLE;
			op           <= fpad_pkg::FPAD_NONE;
			cnt          <= 3'h0;
			total        <= 3'h0;
			dbl          <= 1'b0;
			// operands
			src1         <= 64'h0;
			src2         <= 64'h0;
			dst          <= 5'h0;
			// answer side
			result_valid <= 1'b0;
			result_reg   <= 5'h0;
			result       <= 64'h0;
			illegal      <= 1'b0;
			link.busy    <= 1'b0;
		end else begin
			// control state
			st           <= next_st;
			op           <= next_op;
			cnt          <= next_cnt;
			total        <= next_total;
			dbl          <= next_dbl;
			// operands
			src1         <= next_src1;
			src2         <= next_src2;
			dst          <= next_dst;
			// answer side
			result_valid <= next_result_valid;
			result_reg   <= next_result_reg;
			result       <= next_result;
			illegal      <= next_illegal;
			link.busy    <= next_busy;
		end
	end
endmodule : fpad_unit
`default_nettype wire

// >>> src/fpad_host.sv
/*
 * host end: issues one instruction word, then, unless cmd_mode is 0, feeds operand words either from
 * its two general-register values or from memory via the pointer register.
 * assumes memory answers in the same cycle (mem_addr -> mem_rdata).
 */
`timescale 1ns/100ps
`default_nettype none
module fpad_host (
	input  wire logic        clk,
	input  wire logic        rst_n,
	fpad_if.host             link,
	input  wire logic        start,
	input  wire logic [31:0] cmd_word,
	input  wire logic [1:0]  cmd_mode,   // 0 none, 1 host regs, 2 post-inc, 3 pre-dec
	input  wire logic [2:0]  cmd_count,
	input  wire logic [31:0] gen_reg1,
	input  wire logic [31:0] gen_reg2,
	input  wire logic [31:0] ptr_init,
	output logic [31:0]      mem_addr,
	input  wire logic [31:0] mem_rdata,
	output logic [31:0]      host_pointer_reg,
	output logic             done
);
	typedef enum logic [1:0] {FPAH_IDLE, FPAH_SEND, FPAH_WAIT} fpah_st_t;

	fpah_st_t    st, next_st;
	logic [1:0]  mode, next_mode;
	logic [2:0]  left, next_left, sent, next_sent;
	logic [31:0] next_ptr, next_addr, next_word, fetch_addr;
	logic        next_iv, next_wv, next_done;
	logic [31:0] next_instr;

	// predecrement moves the pointer before the fetch
	assign fetch_addr = (mode == 2'h3) ? host_pointer_reg - fpad_pkg::PTR_STEP
		: host_pointer_reg;

	// ==========================================================
	// issue, then one operand word per cycle until the count runs out
	always_comb begin
		next_st    = st;
		next_mode  = mode;
		next_left  = left;
		next_sent  = sent;
		next_ptr   = host_pointer_reg;
		next_word  = link.word;
		next_iv    = 1'b0;
		next_wv    = 1'b0;
		next_done  = 1'b0;
		next_instr = link.instr;
		case (st)
			FPAH_IDLE: begin
				if (start && !link.busy) begin
					next_instr = cmd_word;
					next_iv    = 1'b1;
					next_mode  = cmd_mode;
					next_left  = cmd_count;
					next_sent  = 3'h0;
					next_ptr   = ptr_init;
					next_st    = (cmd_mode == 2'h0) ? FPAH_WAIT : FPAH_SEND;
				end
			end
			FPAH_SEND: begin
				next_wv = 1'b1;
				if (mode == 2'h1) begin
					next_word = (sent == 3'h0) ? gen_reg1 : gen_reg2;
				end else begin
					// mem_addr already shows this fetch, so the data stands now
					next_word = mem_rdata;
					next_ptr  = (mode == 2'h2) ? host_pointer_reg + fpad_pkg::PTR_STEP
						: fetch_addr;
				end
				next_sent = sent + 3'h1;
				next_left = left - 3'h1;
				if (left == 3'h1) begin
					next_st = FPAH_WAIT;
				end
			end
			FPAH_WAIT: begin
				if (!link.busy && !link.instr_valid && !link.word_valid) begin
					next_done = 1'b1;
					next_st   = FPAH_IDLE;
				end
			end
			default: begin
				next_st = FPAH_IDLE;
			end
		endcase
		// the address leads the data by a cycle: it always shows the next
		// fetch, one step below the pointer when walking down
		next_addr = (next_mode == 2'h3) ? next_ptr - fpad_pkg::PTR_STEP
			: next_ptr;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st               <= FPAH_IDLE;
			mode             <= 2'h0;
			left             <= 3'h0;
			sent             <= 3'h0;
			host_pointer_reg <= 32'h0;
			mem_addr         <= 32'h0;
			done             <= 1'b0;
			link.instr_valid <= 1'b0;
			link.instr       <= 32'h0;
			link.word_valid  <= 1'b0;
			link.word        <= 32'h0;
		end else begin
			st               <= next_st;
			mode             <= next_mode;
			left             <= next_left;
			sent             <= next_sent;
			host_pointer_reg <= next_ptr;
			mem_addr         <= next_addr;
			done             <= next_done;
			link.instr_valid <= next_iv;
			link.instr       <= next_instr;
			link.word_valid  <= next_wv;
			link.word        <= next_word;
		end
	end
endmodule : fpad_host
`default_nettype wire

// >>> bench/fpad_link_sva.sv
/* link checker for the add decode block.
   assumes one clock, async active-low reset and a fixed unit number. */
`timescale 1ns/100ps
`default_nettype none
// ====
// link rules
module fpad_link_sva #(
	parameter logic [2:0] UNIT = 3'h5
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        instr_valid,
	input wire logic [31:0] instr,
	input wire logic        word_valid,
	input wire logic        busy
);
	logic [15:0] opc;
	logic        mem_op;
	// memory forms found by care mask, so t and s never hide one
	assign opc = instr[15:0];
	assign mem_op = ((opc & fpad_pkg::MASK_TS) == fpad_pkg::OPC_MEM_ADD)
		|| ((opc & fpad_pkg::MASK_S) == fpad_pkg::OPC_MEM_ABS);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_pulse; instr_valid |=> !instr_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("long instruction strobe");
	property p_idle; instr_valid |-> !busy; endproperty
	a_idle: assert property (p_idle) else $error("issued while busy");
	property p_dbl; instr_valid && mem_op && instr[7] |=> word_valid [*4] ##1 !word_valid; endproperty
	a_dbl: assert property (p_dbl) else $error("double load not four words");
	property p_sgl; instr_valid && mem_op && !instr[7] |=> word_valid [*2] ##1 !word_valid; endproperty
	a_sgl: assert property (p_sgl) else $error("single load not two words");
	property p_pair;
		instr_valid && opc == fpad_pkg::OPC_HOST_DIFF |=> word_valid [*2] ##1 !word_valid;
	endproperty
	a_pair: assert property (p_pair) else $error("host load not two words");
	property p_reg; instr_valid && opc[15:14] == 2'h0 |=> !word_valid [*3]; endproperty
	a_reg: assert property (p_reg) else $error("words after register form");
	property p_refuse; instr_valid && instr[31:29] != UNIT |=> !busy [*2]; endproperty
	a_refuse: assert property (p_refuse) else $error("foreign unit word taken");
	property p_take; instr_valid && instr[31:29] == UNIT && mem_op |=> ##[0:1] busy; endproperty
	a_take: assert property (p_take) else $error("load not taken");
	property p_ends; $rose(busy) |-> ##[1:12] !busy; endproperty
	a_ends: assert property (p_ends) else $error("busy too long");
endmodule : fpad_link_sva
`default_nettype wire

// >>> bench/fp_coproc_add_abs_decode_bench.sv
/* bench: host and unit ends joined by the link, a memory, a note queue.
   assumes package and interface are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module fp_coproc_add_abs_decode_bench;
	localparam logic [2:0] UNIT = 3'h5;
	logic        clk, rst_n, start, result_valid, illegal, done;
	logic [1:0]  cmd_mode;
	logic [2:0]  cmd_count;
	logic [4:0]  result_reg;
	logic [31:0] cmd_word, gen_reg1, gen_reg2, ptr_init, mem_addr, host_pointer_reg, mem_rdata;
	logic [63:0] result;
	logic [31:0] mem [256];
	logic [69:0] q [$];
	int          err_count, compares, ntest;
	// ====
	// ends, link and checker
	fpad_if link (.clk(clk), .rst_n(rst_n));
	fpad_host fpad_host_inst (.clk(clk), .rst_n(rst_n), .link(link.host), .start(start),
		.cmd_word(cmd_word), .cmd_mode(cmd_mode), .cmd_count(cmd_count), .gen_reg1(gen_reg1),
		.gen_reg2(gen_reg2), .ptr_init(ptr_init), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.host_pointer_reg(host_pointer_reg), .done(done));
	fpad_unit fpad_unit_inst (.clk(clk), .rst_n(rst_n), .link(link.unit), .unit_id(UNIT),
		.result_valid(result_valid), .result_reg(result_reg), .result(result), .illegal(illegal));
	fpad_link_sva #(.UNIT(UNIT)) fpad_link_sva_inst (.clk(clk), .rst_n(rst_n),
		.instr_valid(link.instr_valid), .instr(link.instr), .word_valid(link.word_valid),
		.busy(link.busy));
	// memory answers in the same cycle; 256 words is plenty for one pointer walk
	assign mem_rdata = mem[mem_addr[12:5]];
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [63:0] mag(input logic [63:0] v);
		return v[63] ? -v : v;
	endfunction : mag
	task automatic chk(input string nm, input logic [69:0] ex, input logic [69:0] sn);
		compares++;
		if (ex !== sn) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	// place operands where the pointer walk will find them, issue, wait for done
	task automatic run(input logic [31:0] iw, input logic [1:0] m, input logic [2:0] n,
		input bit note, input logic [69:0] e, input logic [31:0] d [4]);
		int j;
		for (j = 0; j < 4; j++)
			mem[m[0] ? 8'(ptr_init[12:5] - j - 1) : 8'(ptr_init[12:5] + j)] = d[j];
		gen_reg1 = d[0];
		gen_reg2 = d[1];
		cmd_word = iw;
		cmd_mode = m;
		cmd_count = n;
		if (note)
			q.push_back(e);
		@(negedge clk) start = 1'b1;
		@(negedge clk) start = 1'b0;
		for (j = 0; j < 40 && done !== 1'b1; j++)
			@(negedge clk);
		chk("done", 70'h1, 70'(done));
		if (m[1]) chk("pointer", 70'(m[0] ? ptr_init - 32'(n) * fpad_pkg::PTR_STEP
			: ptr_init + 32'(n) * fpad_pkg::PTR_STEP), 70'(host_pointer_reg));
		ntest++;
		$display("test %0d done", ntest);
	endtask : run
	// answers are matched against the oldest note, looked at mid-cycle
	// so the edge that launches them cannot race the look
	always @(negedge clk) begin
		if (rst_n && (result_valid === 1'b1 || illegal === 1'b1)) begin
			if (q.size() == 0) chk("stray answer", 70'h0, 70'h1);
			else if (q[0][69]) chk("illegal", q.pop_front(), {illegal, 69'h0});
			else chk("result", q.pop_front(), {illegal, result_reg, result});
		end
	end
	initial begin
		#100000;
		err_count++;
		$display("unexpected timeout expected done seen hang");
		final_report();
	end
	initial begin
		logic [63:0] a, b, s;
		logic [31:0] w [4];
		logic [15:0] opc;
		logic [15:0] bad [4];
		logic [3:0]  s1, s2;
		logic [4:0]  rd;
		logic        sz;
		int          i, k;
		bad = '{16'h4000, 16'h5780, 16'h0200, 16'h1f00};
		rst_n = 1'b0;
		start = 1'b0;
		{cmd_word, cmd_mode, cmd_count, gen_reg1, gen_reg2, ptr_init} = '0;
		void'($urandom(32'h3f62d22e));
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		// both walks, every add type and size, then register forms on the loaded sources
		for (i = 0; i < 13; i++) begin
			k = (i % 6) / 2;
			sz = i[0] && i < 12;
			for (int j = 0; j < 4; j++)
				w[j] = $urandom;
			if (!sz) begin
				w[0] = {4'h1, w[0][27:0]};
				w[1] = {4'h0, w[1][27:0]};
			end
			a = sz ? {w[0], w[1]} : {32'h0, w[0]};
			b = sz ? {w[2], w[3]} : {32'h0, w[1]};
			s = (k == 2) ? mag(a + b) : a + b;
			opc = (k == 2) ? fpad_pkg::OPC_MEM_ABS : fpad_pkg::OPC_MEM_ADD | {7'h0, k[0], 8'h0};
			opc = opc | {8'h0, sz, 7'h0};
			s1 = {2'h0, 2'($urandom)};
			s2 = {2'h2, 2'($urandom)};
			rd = {1'($urandom), 2'h1, 2'($urandom)};
			ptr_init = {27'($urandom), 5'h0};
			if (i == 12) begin
				run({UNIT, s1, s2, rd, fpad_pkg::OPC_HOST_DIFF}, 2'h1, 3'h2, 1'b1, {1'b0, rd, a - b}, w);
			end else begin
				run({UNIT, s1, s2, rd, opc}, {1'b1, i >= 6}, sz ? 3'h4 : 3'h2, 1'b1, {1'b0, rd, s}, w);
				run({UNIT, s1, s2, rd, {8'h0, sz, 7'h0}}, 2'h0, 3'h0, 1'b1, {1'b0, rd, a + b}, w);
				run({UNIT, s1, s2, rd, fpad_pkg::OPC_REG_DIFF | {8'h0, sz, 7'h0}}, 2'h0, 3'h0, 1'b1,
					{1'b0, rd, mag(a) - mag(b)}, w);
			end
		end
		for (i = 0; i < 4; i++)
			run({UNIT, s1, s2, rd, bad[i]}, 2'h0, 3'h0, 1'b1, {1'b1, 69'h0}, w);
		run({UNIT ^ 3'h1, s1, s2, rd, 16'h0000}, 2'h0, 3'h0, 1'b0, 70'h0, w);
		repeat (4) @(negedge clk);
		chk("pending notes", 70'h0, 70'(q.size()));
		final_report();
	end
endmodule : fp_coproc_add_abs_decode_bench
`default_nettype wire
